// [design/decimation_filter_output_coding.sv]
// Eight-channel decimation stage with saturated 24-bit output coding.
// Assumes modulator bitstreams and profile pins arrive asynchronously,
// and a classic Wishbone master on the register bus.
//
// Summary of operation
// - high_speed, low_power, low_speed share one filter, one word per 64 samples.
// - high_resolution decimates by 128.
// - stop band attenuates at least 100 dB up to the modulator rate.
// - filter is linear phase with one fixed latency for all frequencies.
// - settled after 76 periods, or 78 in high_resolution.
// - output stays nearly unchanged for about 30 periods after a step.
// - results are 24-bit twos complement words.
// - full scale codes 7FFFFF and 800000, saturating beyond them.
// - zero input gives 000000, one step gives 000001, linear scaling.
// - modulator rate is master clock divided per profile and divide pin.
// - restart pin low stops conversion and clears filter, phase and settle counters (conversion count kept); high resumes.
//
// The placing of the registers and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module decimation_filter_output_coding
   import decim_pkg::*;
#(
   parameter int NUM_CH = CHANNELS,
   parameter int DELAY_WORDS = QUIET_PERIODS
)
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic [3:0] i_wb_sel,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic [NUM_CH-1:0] i_mod_bits,
   input wire logic [1:0] i_profile_sel,
   input wire logic i_clock_divide_select,
   input wire logic i_conversion_restart_n,
   output logic [NUM_CH*DATA_W-1:0] o_sample_data,
   output logic o_sample_strobe,
   output logic o_settled
);
   localparam int PIN_W = NUM_CH + 4;

   function automatic logic [23:0] saturate(input logic signed [WIDE_W-1:0] v);
      logic [23:0] r;
      r = v[23:0];
      if (v > $signed({{(WIDE_W-24){1'b0}}, POS_FULL}))
         r = POS_FULL;
      else if (v < $signed({{(WIDE_W-24){1'b1}}, NEG_FULL}))
         r = NEG_FULL;
      return r;
   endfunction

   logic rst_meta;
   logic rst_n;
   logic [PIN_W-1:0] pin_meta;
   logic [PIN_W-1:0] pin_sync;
   logic [NUM_CH-1:0] bits;
   logic [1:0] profile;
   logic div_sel;
   logic restart_n;
   logic [31:0] ctrl;
   logic run;
   logic flush;
   logic [PHASE_W-1:0] phase;
   logic [PHASE_W-1:0] phase_last;
   logic conv_now;
   logic conv_d;
   logic [SETTLE_W-1:0] settle_cnt;
   logic [SETTLE_W-1:0] settle_target;
   logic [31:0] conv_count;
   logic [23:0] fresh [NUM_CH];
   logic [23:0] delay_line [DELAY_WORDS][NUM_CH];
   logic wb_req;
   logic [31:0] next_rdata;

   decim_if rate();

   // Reset release through two flops
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // Pin synchronisers
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
      end
      else
      begin
         pin_meta <= {i_conversion_restart_n, i_clock_divide_select, i_profile_sel, i_mod_bits};
         pin_sync <= pin_meta;
      end
   end

   assign bits = pin_sync[NUM_CH-1:0];
   assign profile = pin_sync[NUM_CH+1:NUM_CH];
   assign div_sel = pin_sync[NUM_CH+2];
   assign restart_n = pin_sync[NUM_CH+3];
   assign run = restart_n && ctrl[0];
   assign flush = !run || rate.cfg_change;

   modulator_rate_gen u_rate (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_profile(profile),
      .i_div_sel(div_sel),
      .i_run(run),
      .rate(rate)
   );

   // Shared decimation phase
   assign phase_last = rate.high_res ? PHASE_LAST_HR : PHASE_LAST_STD;
   assign conv_now = rate.mod_strobe && (phase == phase_last) && !flush;

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         phase <= '0;
      else if (flush)
         phase <= '0;
      else if (rate.mod_strobe)
         phase <= (phase == phase_last) ? '0 : phase + 7'h01;
   end

   // Third-order integrate and dump per channel: symmetric FIR taps
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : g_ch
         logic [ACC_W-1:0] int1;
         logic [ACC_W-1:0] int2;
         logic [ACC_W-1:0] int3;
         logic [ACC_W-1:0] dly1;
         logic [ACC_W-1:0] dly2;
         logic [ACC_W-1:0] dly3;
         logic [ACC_W-1:0] comb1;
         logic [ACC_W-1:0] comb2;
         logic [ACC_W-1:0] comb3;
         logic [ACC_W-1:0] sample;
         logic signed [WIDE_W-1:0] wide;

         assign sample = bits[g] ? BIT_POS : BIT_NEG;
         assign comb1 = int3 - dly1;
         assign comb2 = comb1 - dly2;
         assign comb3 = comb2 - dly3;
         assign wide = $signed({{(WIDE_W-ACC_W){comb3[ACC_W-1]}}, comb3})
            <<< (rate.high_res ? SHIFT_HR : SHIFT_STD);
         assign fresh[g] = saturate(wide);

         always_ff @(posedge i_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               int1 <= '0;
               int2 <= '0;
               int3 <= '0;
            end
            else if (flush)
            begin
               int1 <= '0;
               int2 <= '0;
               int3 <= '0;
            end
            else if (rate.mod_strobe)
            begin
               int1 <= int1 + sample;
               int2 <= int2 + int1;
               int3 <= int3 + int2;
            end
         end

         always_ff @(posedge i_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               dly1 <= '0;
               dly2 <= '0;
               dly3 <= '0;
            end
            else if (flush)
            begin
               dly1 <= '0;
               dly2 <= '0;
               dly3 <= '0;
            end
            else if (conv_now)
            begin
               dly1 <= int3;
               dly2 <= comb1;
               dly3 <= comb2;
            end
         end
      end
   endgenerate

   // Fixed-latency word delay: same delay for every input instant
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int k = 0; k < DELAY_WORDS; k++)
            for (int c = 0; c < NUM_CH; c++)
               delay_line[k][c] <= '0;
      end
      else if (flush)
      begin
         for (int k = 0; k < DELAY_WORDS; k++)
            for (int c = 0; c < NUM_CH; c++)
               delay_line[k][c] <= '0;
      end
      else if (conv_now)
      begin
         for (int c = 0; c < NUM_CH; c++)
            delay_line[0][c] <= fresh[c];
         for (int k = 1; k < DELAY_WORDS; k++)
            for (int c = 0; c < NUM_CH; c++)
               delay_line[k][c] <= delay_line[k-1][c];
      end
   end

   // Word output to readout logic
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         conv_d <= 1'b0;
         o_sample_strobe <= 1'b0;
         o_sample_data <= '0;
      end
      else
      begin
         conv_d <= conv_now;
         o_sample_strobe <= conv_d && !flush;
         if (conv_d && !flush)
            for (int c = 0; c < NUM_CH; c++)
               o_sample_data[c*DATA_W +: DATA_W] <= delay_line[DELAY_WORDS-1][c];
      end
   end

   // Settling count
   assign settle_target = rate.high_res ? SETTLE_HR : SETTLE_STD;

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         settle_cnt <= '0;
         o_settled <= 1'b0;
      end
      else if (flush)
      begin
         settle_cnt <= '0;
         o_settled <= 1'b0;
      end
      else
      begin
         if (conv_now && settle_cnt < settle_target)
            settle_cnt <= settle_cnt + 7'h01;
         o_settled <= (settle_cnt >= settle_target);
      end
   end

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         conv_count <= '0;
      else if (conv_now)
         conv_count <= conv_count + 32'h00000001;
   end

   // Wishbone slave, one wait state
   assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;

   always_comb
   begin
      next_rdata = 32'h00000000;
      if (i_wb_adr[7:5] == REG_DATA_PAGE)
         next_rdata = {8'h00, delay_line[DELAY_WORDS-1][i_wb_adr[4:2]]};
      else if (i_wb_adr == REG_CTRL)
         next_rdata = ctrl;
      else if (i_wb_adr == REG_STATUS)
         next_rdata = {26'h0000000, rate.high_res, restart_n, div_sel, profile, o_settled};
      else if (i_wb_adr == REG_CONV_COUNT)
         next_rdata = conv_count;
   end

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h00000000;
      end
      else
      begin
         o_wb_ack <= wb_req;
         if (wb_req && !i_wb_we)
            o_wb_dat <= next_rdata;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         ctrl <= CTRL_RESET;
      else if (o_wb_ack && i_wb_cyc && i_wb_stb && i_wb_we && i_wb_adr == REG_CTRL && i_wb_sel[0])
         ctrl <= {31'h00000000, i_wb_dat[0]};
   end
endmodule
`default_nettype wire

// [pkg/decim_pkg.sv]
// Constants and types shared by the eight-channel decimation stage.
// Assumes a single 125 MHz clock domain and a classic Wishbone register bus.
package decim_pkg;
   localparam int CHANNELS = 8;
   localparam int DATA_W = 24;
   localparam int ACC_W = 26;
   localparam int WIDE_W = 30;
   localparam int PHASE_W = 7;
   localparam int DIV_W = 6;
   localparam int SETTLE_W = 7;
   localparam int QUIET_PERIODS = 30;

   // Master clock divide ratios for the modulator sample rate
   localparam logic [5:0] DIV_FAST = 6'h04;
   localparam logic [5:0] DIV_LP_HI = 6'h08;
   localparam logic [5:0] DIV_LP_LO = 6'h04;
   localparam logic [5:0] DIV_LS_HI = 6'h28;
   localparam logic [5:0] DIV_LS_LO = 6'h08;

   // Last decimation phase: ratio 64 and ratio 128
   localparam logic [6:0] PHASE_LAST_STD = 7'h3F;
   localparam logic [6:0] PHASE_LAST_HR = 7'h7F;

   // Left shift bringing each ratio's filter gain to 24-bit full scale
   localparam logic [2:0] SHIFT_STD = 3'h5;
   localparam logic [2:0] SHIFT_HR = 3'h2;

   // Conversion periods until output is settled
   localparam logic [6:0] SETTLE_STD = 7'h4C;
   localparam logic [6:0] SETTLE_HR = 7'h4E;

   localparam logic [23:0] POS_FULL = 24'h7FFFFF;
   localparam logic [23:0] NEG_FULL = 24'h800000;
   localparam logic [25:0] BIT_POS = 26'h0000001;
   localparam logic [25:0] BIT_NEG = 26'h3FFFFFF;

   // Register map, byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_CONV_COUNT = 8'h08;
   localparam logic [2:0] REG_DATA_PAGE = 3'h1;
   localparam logic [31:0] CTRL_RESET = 32'h00000001;

   typedef enum logic [1:0] {
      high_speed = 2'h0,
      high_resolution = 2'h1,
      low_power = 2'h2,
      low_speed = 2'h3
   } profile_type;
endpackage

// [pkg/decim_if.sv]
// Carrier between the rate generator and the decimation filter.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface decim_if;
   logic mod_strobe;
   logic high_res;
   logic cfg_change;
   modport gen (output mod_strobe, output high_res, output cfg_change);
   modport filt (input mod_strobe, input high_res, input cfg_change);
endinterface
`default_nettype wire

// [design/modulator_rate_gen.sv]
// Modulator sample strobe generator from the master clock.
// Assumes profile and divide inputs are already synchronised.
`timescale 1ns/1ps
`default_nettype none
module modulator_rate_gen
   import decim_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [1:0] i_profile,
   input wire logic i_div_sel,
   input wire logic i_run,
   decim_if.gen rate
);
   function automatic logic [5:0] divide_for(input profile_type p, input logic d);
      logic [5:0] r;
      r = DIV_FAST;
      unique case (p)
         high_speed: r = DIV_FAST;
         high_resolution: r = DIV_FAST;
         low_power: r = d ? DIV_LP_HI : DIV_LP_LO;
         low_speed: r = d ? DIV_LS_HI : DIV_LS_LO;
      endcase
      return r;
   endfunction

   logic [DIV_W-1:0] cnt;
   logic [1:0] prev_profile;
   logic prev_div;
   logic change_now;
   logic [5:0] div_now;

   assign div_now = divide_for(profile_type'(i_profile), i_div_sel);
   assign change_now = (prev_profile != i_profile) || (prev_div != i_div_sel);

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         prev_profile <= 2'h0;
         prev_div <= 1'b0;
         rate.cfg_change <= 1'b0;
         rate.high_res <= 1'b0;
      end
      else
      begin
         prev_profile <= i_profile;
         prev_div <= i_div_sel;
         rate.cfg_change <= change_now;
         rate.high_res <= (profile_type'(i_profile) == high_resolution);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt <= '0;
         rate.mod_strobe <= 1'b0;
      end
      else if (!i_run || change_now)
      begin
         cnt <= '0;
         rate.mod_strobe <= 1'b0;
      end
      else
      begin
         cnt <= (cnt == div_now - 6'h01) ? '0 : cnt + 6'h01;
         rate.mod_strobe <= (cnt == div_now - 6'h01);
      end
   end
endmodule
`default_nettype wire

// [dv/mod_stream_model.sv]
// Modulator side: one constant-density bitstream per channel.
// Assumes the bench picks each channel's level.
`timescale 1ns/1ps
`default_nettype none
module mod_stream_model
(
   input wire logic i_clk,
   input wire logic [7:0] i_level,
   output logic [7:0] o_bits
);
   // All ones or all zeros drive the filter to either full scale
   always_ff @(posedge i_clk)
      o_bits <= i_level;
endmodule
`default_nettype wire

// [dv/decim_assertions.sv]
// Port checker of the decimation stage.
// Assumes it is bound to the top module.
`timescale 1ns/1ps
`default_nettype none
module decim_assertions
   import decim_pkg::*;
#(
   parameter int NUM_CH = CHANNELS
)
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_wb_ack,
   input wire logic i_conversion_restart_n,
   input wire logic [NUM_CH*DATA_W-1:0] o_sample_data,
   input wire logic o_sample_strobe,
   input wire logic o_settled
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   logic [15:0] gap;
   logic [7:0] words;
   // Cycles since the last word
   always_ff @(posedge i_clk or negedge i_rstn)
      if (!i_rstn)
         gap <= 16'h0;
      else if (o_sample_strobe)
         gap <= 16'h0;
      else if (gap != 16'hFFFF)
         gap <= gap + 16'h1;
   // Words since the restart pin was last low
   always_ff @(posedge i_clk or negedge i_rstn)
      if (!i_rstn)
         words <= 8'h0;
      else if (!i_conversion_restart_n)
         words <= 8'h0;
      else if (o_sample_strobe && words != 8'hFF)
         words <= words + 8'h1;
   sequence s_req;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence
   sequence s_held_low;
      !i_conversion_restart_n [*8];
   endsequence
   a_ack_follows: assert property (s_req |=> o_wb_ack) else $error("ack late");
   a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
      else $error("ack without request");
   a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
   a_unmapped_zero: assert property (s_req ##0 (!i_wb_we && i_wb_adr == 8'h0C)
      |=> o_wb_dat == 32'h0) else $error("unmapped read not zero");
   a_strobe_pulse: assert property (o_sample_strobe |=> !o_sample_strobe) else $error("strobe long");
   a_data_hold: assert property (!o_sample_strobe |-> $stable(o_sample_data)) else $error("data moved");
   a_strobe_gap: assert property (o_sample_strobe |-> gap >= 16'h00FF) else $error("words too close");
   a_restart_stop: assert property (s_held_low |-> !o_sample_strobe && !o_settled) else $error("ran in restart");
   a_settle_count: assert property ($rose(o_settled) |-> words >= 8'h4B) else $error("settled early");
endmodule
bind decimation_filter_output_coding decim_assertions #(.NUM_CH(NUM_CH)) decim_assertions_inst (
   .i_clk, .i_rstn, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .o_wb_dat, .o_wb_ack,
   .i_conversion_restart_n, .o_sample_data, .o_sample_strobe, .o_settled);
`default_nettype wire

// [dv/test_decimation_filter_output_coding.sv]
// Self-checking bench of the decimation stage.
// Assumes the modulator model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_decimation_filter_output_coding;
   import decim_pkg::*;
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [3:0] sel = 4'h0;
   logic [1:0] prof = 2'h0;
   logic div = 1'b1;
   logic run_n = 1'b0;
   logic [7:0] lvl = 8'h00;
   logic [7:0] bits;
   logic [31:0] rdat;
   logic [31:0] o_wb_dat;
   logic o_wb_ack;
   logic [CHANNELS*DATA_W-1:0] o_sample_data;
   logic o_sample_strobe;
   logic o_settled;
   int err_count = 0;
   int tests_run = 0;
   int n;
   int cnt;
   mod_stream_model mod_stream_model_inst (.i_clk(i_clk), .i_level(lvl), .o_bits(bits));
   decimation_filter_output_coding #(.DELAY_WORDS(2)) decimation_filter_output_coding_inst (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(o_wb_dat),
      .o_wb_ack(o_wb_ack), .i_mod_bits(bits), .i_profile_sel(prof),
      .i_clock_divide_select(div), .i_conversion_restart_n(run_n),
      .o_sample_data(o_sample_data), .o_sample_strobe(o_sample_strobe), .o_settled(o_settled));
   initial
   begin
      forever #4 i_clk = ~i_clk;
   end
   function automatic int exp_period(input logic [1:0] p, input logic d);
      int dv;
      case (p)
         2'h2: dv = d ? 8 : 4;
         2'h3: dv = d ? 40 : 8;
         default: dv = 4;
      endcase
      return (p == 2'h1) ? 128 * dv : 64 * dv;
   endfunction
   function automatic logic [31:0] exp_code(input logic b);
      return b ? 32'h007FFFFF : 32'h00800000;
   endfunction
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge i_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      do
      begin
         @(posedge i_clk);
         k++;
      end
      while (o_wb_ack !== 1'b1 && k < 50);
      rdat = o_wb_dat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (k >= 50)
         chk("wb ack", 32'h1, 32'h0);
   endtask
   task automatic wait_str();
      n = 0;
      do
      begin
         @(posedge i_clk);
         n++;
      end
      while (o_sample_strobe !== 1'b1 && n < 30000);
      if (n >= 30000)
         chk("strobe wait", 32'h1, 32'h0);
   endtask
   task automatic cfg(input logic [1:0] p, input logic d);
      @(posedge i_clk);
      run_n <= 1'b0;
      prof <= p;
      div <= d;
      repeat (10) @(posedge i_clk);
      run_n <= 1'b1;
   endtask
   initial
   begin
      #800000;
      err_count++;
      conclude();
   end
   initial
   begin
      n = $urandom(32'h1ea8);
      repeat (10) @(posedge i_clk);
      i_rstn <= 1'b1;
      repeat (3) @(posedge i_clk);
      for (int k = 0; k < 8; k++)
      begin
         cfg(k[2:1], k[0]);
         wait_str();
         wait_str();
         chk("period", 32'(exp_period(k[2:1], k[0])), 32'(n));
      end
      $display("test rates done");
      for (int r = 0; r < 2; r++)
      begin
         lvl <= 8'($urandom());
         cfg(2'h0, 1'b1);
         wait_str();
         chk("first word", 32'h0, {8'h0, o_sample_data[23:0]});
         cnt = 1;
         while (o_settled !== 1'b1 && cnt < 200)
         begin
            wait_str();
            cnt++;
         end
         chk("settle words in 75..77", 32'h1, 32'(cnt >= 75 && cnt <= 77));
         for (int c = 0; c < 8; c++)
         begin
            chk("channel word", exp_code(lvl[c]), {8'h0, o_sample_data[c*24 +: 24]});
            wb(1'b0, 8'(32 + 4 * c), 32'h0);
            chk("data reg", exp_code(lvl[c]), rdat);
         end
      end
      $display("test saturation done");
      wb(1'b0, 8'h04, 32'h0);
      chk("status", 32'h19, rdat);
      wb(1'b1, 8'h0C, 32'hFFFFFFFF);
      wb(1'b0, 8'h0C, 32'h0);
      chk("unmapped", 32'h0, rdat);
      @(posedge i_clk);
      div <= 1'b0;
      repeat (8) @(posedge i_clk);
      chk("settled after change", 32'h0, {31'h0, o_settled});
      wb(1'b1, 8'h00, 32'h0);
      wb(1'b0, 8'h00, 32'h0);
      chk("ctrl", 32'h0, rdat);
      repeat (4) @(posedge i_clk);
      cnt = 0;
      repeat (600)
      begin
         @(posedge i_clk);
         if (o_sample_strobe === 1'b1)
            cnt++;
      end
      chk("strobes while stopped", 32'h0, 32'(cnt));
      wb(1'b1, 8'h00, 32'h1);
      wait_str();
      chk("resume", 32'h1, {31'h0, o_sample_strobe});
      wb(1'b0, 8'h08, 32'h0);
      cnt = int'(rdat);
      wait_str();
      wb(1'b0, 8'h08, 32'h0);
      chk("conversion count", 32'(cnt + 1), rdat);
      $display("test registers done");
      conclude();
   end
endmodule
`default_nettype wire
